// ---- rtl/ppr_pkg.sv ----
// Package: register map, selector codes, reset defaults and carrier types for the pin routing block
package ppr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int unsigned NUM_PINS   = 24;
  localparam int unsigned NUM_INPUTS = 25;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned SEL_W      = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [11:0] LOCK_ADDR  = 12'h000;
  localparam logic [11:0] IN_BASE    = 12'h100;
  localparam logic [11:0] OUT_BASE   = 12'h200;
  localparam int unsigned LOCK_BIT   = 0;
  localparam logic [4:0]  SEL_RESET  = 5'h00;
  localparam logic        LOCK_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Port field of an input selector
  localparam logic [1:0] PORT_A     = 2'h0;
  localparam logic [1:0] PORT_B     = 2'h1;
  localparam logic [1:0] PORT_C     = 2'h2;
  localparam logic [1:0] PORT_RSVD  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Pin output source codes
  localparam logic [4:0] OUT_LATCH    = 5'h00;
  localparam logic [4:0] OUT_WG_A     = 5'h01;
  localparam logic [4:0] OUT_WG_B     = 5'h02;
  localparam logic [4:0] OUT_WG_C     = 5'h03;
  localparam logic [4:0] OUT_WG_D     = 5'h04;
  localparam logic [4:0] OUT_CAPTURE_COMPARE_UNIT_1     = 5'h05;
  localparam logic [4:0] OUT_CAPTURE_COMPARE_UNIT_2     = 5'h06;
  localparam logic [4:0] OUT_PULSE_WIDTH_UNIT_3     = 5'h07;
  localparam logic [4:0] OUT_PULSE_WIDTH_UNIT_4     = 5'h08;
  localparam logic [4:0] OUT_ASYNC_TX = 5'h09;
  localparam logic [4:0] OUT_ASYNC_RX = 5'h0A;
  localparam logic [4:0] OUT_COMPARATOR_1_OUT     = 5'h0D;
  localparam logic [4:0] OUT_COMPARATOR_2_OUT     = 5'h0E;
  localparam logic [4:0] OUT_SSP_CLK  = 5'h0F;
  localparam logic [4:0] OUT_SSP_DATA = 5'h10;
  localparam logic [4:0] OUT_TIMER0   = 5'h13;
  localparam logic [4:0] OUT_REF_CLK  = 5'h14;
  localparam logic [4:0] OUT_MOD      = 5'h15;
  localparam logic [4:0] OUT_GUARD_A  = 5'h16;
  localparam logic [4:0] OUT_GUARD_B  = 5'h17;

  ////////////////////////////////////////////////////////////////////////////
  // Input selector power-on defaults, index 24 first (async transmit .. ext_irq0)
  localparam logic [24:0][4:0] IN_DEFAULT = {
    5'h16, 5'h17, 5'h05, 5'h14, 5'h13, 5'h0C, 5'h05, 5'h04, 5'h03,
    5'h08, 5'h11, 5'h12, 5'h0F, 5'h15, 5'h13, 5'h0C, 5'h12, 5'h10,
    5'h10, 5'h0D, 5'h10, 5'h04, 5'h0A, 5'h09, 5'h08};
  // Ports each input may be taken from: bit 0 A, bit 1 B, bit 2 C
  localparam logic [24:0][2:0] IN_PORTS = {
    3'h6, 3'h6, 3'h5, 3'h6, 3'h6, 3'h6, 3'h5, 3'h5, 3'h5,
    3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h5, 3'h6, 3'h5, 3'h5,
    3'h6, 3'h6, 3'h5, 3'h3, 3'h3, 3'h3, 3'h3};

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic waveform_gen_out_a;
    logic waveform_gen_out_b;
    logic waveform_gen_out_c;
    logic waveform_gen_out_d;
    logic capture_compare_unit_1;
    logic capture_compare_unit_2;
    logic pulse_width_unit_3;
    logic pulse_width_unit_4;
    logic async_tx;
    logic async_rx;
    logic comparator_1_out;
    logic comparator_2_out;
    logic sync_clk;
    logic sync_data;
    logic timer0_output;
    logic reference_clock_out;
    logic signal_modulator_out;
    logic adc_guard_out_a;
    logic adc_guard_out_b;
  } ppr_src_t;

  typedef enum logic [1:0] {
    PPR_REG_NONE = 2'h0,
    PPR_REG_LOCK = 2'h1,
    PPR_REG_IN   = 2'h3,
    PPR_REG_OUT  = 2'h2
  } ppr_reg_kind_t;

  typedef struct packed {
    ppr_reg_kind_t kind;
    logic [4:0]    idx;
  } ppr_decode_t;

endpackage : ppr_pkg

// ---- rtl/ppr_pin_router.sv ----
// Peripheral pin routing block with AXI4-Lite register slave
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module ppr_pin_router #(
  parameter int unsigned NUM_PINS   = ppr_pkg::NUM_PINS,
  parameter int unsigned NUM_INPUTS = ppr_pkg::NUM_INPUTS
) (
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic                     warm_rst,
  input  wire logic [11:0]              awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [11:0]              araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  input  wire logic [NUM_PINS-1:0]      pin_output_latch,
  input  wire ppr_pkg::ppr_src_t        periph_src,
  input  wire logic [NUM_PINS-1:0]      pin_in,
  output logic [NUM_PINS-1:0]           pin_out,
  output logic [NUM_INPUTS-1:0]         peripheral_input,
  output logic                          routing_locked_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic ppr_pkg::ppr_decode_t decode(input logic [11:0] a);
    ppr_pkg::ppr_decode_t d;
    d.kind = ppr_pkg::PPR_REG_NONE;
    d.idx  = 5'h00;
    if (a[1:0] != 2'h0) begin
      d.kind = ppr_pkg::PPR_REG_NONE;
    end else if (a == ppr_pkg::LOCK_ADDR) begin
      d.kind = ppr_pkg::PPR_REG_LOCK;
    end else if (a >= ppr_pkg::IN_BASE && a < ppr_pkg::IN_BASE + 12'(4 * NUM_INPUTS)) begin
      d.kind = ppr_pkg::PPR_REG_IN;
      d.idx  = 5'((a - ppr_pkg::IN_BASE) >> 2);
    end else if (a >= ppr_pkg::OUT_BASE && a < ppr_pkg::OUT_BASE + 12'(4 * NUM_PINS)) begin
      d.kind = ppr_pkg::PPR_REG_OUT;
      d.idx  = 5'((a - ppr_pkg::OUT_BASE) >> 2);
    end
    return d;
  endfunction : decode

  // Codes offered only on some ports fall back to the latch elsewhere
  function automatic logic route_out(input logic [4:0] code, input logic [1:0] port,
                                     input logic latch, input ppr_pkg::ppr_src_t s);
    logic bc;
    logic ac;
    logic v;
    bc = (port == ppr_pkg::PORT_B) || (port == ppr_pkg::PORT_C);
    ac = (port == ppr_pkg::PORT_A) || (port == ppr_pkg::PORT_C);
    v  = latch;
    case (code)
      ppr_pkg::OUT_WG_A:     v = bc ? s.waveform_gen_out_a : latch;
      ppr_pkg::OUT_WG_B:     v = bc ? s.waveform_gen_out_b : latch;
      ppr_pkg::OUT_WG_C:     v = bc ? s.waveform_gen_out_c : latch;
      ppr_pkg::OUT_WG_D:     v = bc ? s.waveform_gen_out_d : latch;
      ppr_pkg::OUT_CAPTURE_COMPARE_UNIT_1:     v = bc ? s.capture_compare_unit_1 : latch;
      ppr_pkg::OUT_CAPTURE_COMPARE_UNIT_2:     v = bc ? s.capture_compare_unit_2 : latch;
      ppr_pkg::OUT_PULSE_WIDTH_UNIT_3:     v = ac ? s.pulse_width_unit_3 : latch;
      ppr_pkg::OUT_PULSE_WIDTH_UNIT_4:     v = ac ? s.pulse_width_unit_4 : latch;
      ppr_pkg::OUT_COMPARATOR_1_OUT:     v = ac ? s.comparator_1_out : latch;
      ppr_pkg::OUT_COMPARATOR_2_OUT:     v = ac ? s.comparator_2_out : latch;
      ppr_pkg::OUT_ASYNC_TX: v = bc ? s.async_tx : latch;
      ppr_pkg::OUT_ASYNC_RX: v = bc ? s.async_rx : latch;
      ppr_pkg::OUT_SSP_CLK:  v = bc ? s.sync_clk : latch;
      ppr_pkg::OUT_SSP_DATA: v = bc ? s.sync_data : latch;
      ppr_pkg::OUT_TIMER0:   v = bc ? s.timer0_output : latch;
      ppr_pkg::OUT_REF_CLK:  v = bc ? s.reference_clock_out : latch;
      ppr_pkg::OUT_MOD:      v = s.signal_modulator_out;
      ppr_pkg::OUT_GUARD_A:  v = ac ? s.adc_guard_out_a : latch;
      ppr_pkg::OUT_GUARD_B:  v = ac ? s.adc_guard_out_b : latch;
      default:               v = latch;
    endcase
    return v;
  endfunction : route_out

  // Selector value is the pin index itself; reserved or absent ports read low
  function automatic logic pick_in(input logic [4:0] sel, input logic [2:0] ports,
                                   input logic [NUM_PINS-1:0] pins);
    logic [1:0] port;
    port = sel[4:3];
    if (port == ppr_pkg::PORT_RSVD || !ports[port]) begin
      return 1'b0;
    end
    return pins[sel];
  endfunction : pick_in

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [4:0]          out_sel [NUM_PINS];
  logic [4:0]          in_sel  [NUM_INPUTS];
  logic                lock;
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic        aw_full;
  logic        w_full;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        next_aw_full;
  logic        next_w_full;
  ppr_pkg::ppr_decode_t wdec;

  assign do_write     = aw_full && w_full && !bvalid;
  assign next_aw_full = (aw_full && !do_write) || (awvalid && awready);
  assign next_w_full  = (w_full && !do_write) || (wvalid && wready);
  assign wdec         = decode(aw_addr);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      awready <= !next_aw_full;
      wready  <= !next_w_full;
      if (awvalid && awready) begin
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp  <= ppr_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= (wdec.kind == ppr_pkg::PPR_REG_NONE) ? ppr_pkg::RESP_SLVERR : ppr_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  logic sel_write;
  assign sel_write = do_write && w_strb[0] && !lock;

  ////////////////////////////////////////////////////////////////////////////
  // Lock register: cleared by every reset kind

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock <= ppr_pkg::LOCK_RESET;
    end else if (warm_rst) begin
      lock <= ppr_pkg::LOCK_RESET;
    end else if (do_write && w_strb[0] && wdec.kind == ppr_pkg::PPR_REG_LOCK) begin
      lock <= w_data[ppr_pkg::LOCK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selectors: only the power-on reset touches them

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        out_sel[i] <= ppr_pkg::SEL_RESET;
      end
    end else if (sel_write && wdec.kind == ppr_pkg::PPR_REG_OUT) begin
      out_sel[wdec.idx] <= w_data[4:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        in_sel[i] <= ppr_pkg::IN_DEFAULT[i];
      end
    end else if (sel_write && wdec.kind == ppr_pkg::PPR_REG_IN) begin
      in_sel[wdec.idx] <= w_data[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, answer one cycle after the address is taken

  ppr_pkg::ppr_decode_t rdec;
  logic                 next_rvalid;
  assign rdec        = decode(araddr);
  assign next_rvalid = (rvalid && !rready) || (arvalid && arready);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid  <= 1'b0;
      arready <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= ppr_pkg::RESP_OKAY;
    end else begin
      rvalid  <= next_rvalid;
      arready <= !next_rvalid;
      if (arvalid && arready) begin
        rresp <= ppr_pkg::RESP_OKAY;
        rdata <= 32'h0000_0000;
        if (rdec.kind == ppr_pkg::PPR_REG_LOCK) begin
          rdata[ppr_pkg::LOCK_BIT] <= lock;
        end else if (rdec.kind == ppr_pkg::PPR_REG_IN) begin
          rdata[4:0] <= in_sel[rdec.idx];
        end else if (rdec.kind == ppr_pkg::PPR_REG_OUT) begin
          rdata[4:0] <= out_sel[rdec.idx];
        end else begin
          rresp <= ppr_pkg::RESP_SLVERR;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= '0;
    end else begin
      for (int p = 0; p < NUM_PINS; p++) begin
        pin_out[p] <= route_out(out_sel[p], 2'(p / 8), pin_output_latch[p], periph_src);
      end
    end
  end

  // Pins come from outside the clock domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      peripheral_input <= '0;
    end else begin
      for (int k = 0; k < NUM_INPUTS; k++) begin
        peripheral_input[k] <= pick_in(in_sel[k], ppr_pkg::IN_PORTS[k], pin_sync);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      routing_locked_flag <= 1'b0;
    end else begin
      routing_locked_flag <= lock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_latch_on_zero: assert property (@(posedge clk) disable iff (!arst_n)
    out_sel[0] == ppr_pkg::OUT_LATCH |=> pin_out[0] == $past(pin_output_latch[0]))
    else $error("pin 0 with code zero does not follow its latch");

  chk_wg_on_port_b: assert property (@(posedge clk) disable iff (!arst_n)
    out_sel[8] == ppr_pkg::OUT_WG_A |=> pin_out[8] == $past(periph_src.waveform_gen_out_a))
    else $error("waveform output A not routed to port B pin");

  chk_tx_port_a: assert property (@(posedge clk) disable iff (!arst_n)
    out_sel[1] == ppr_pkg::OUT_ASYNC_TX |=> pin_out[1] == $past(pin_output_latch[1]))
    else $error("serial transmit leaked onto port A");

  chk_sync_clk_route: assert property (@(posedge clk) disable iff (!arst_n)
    out_sel[16] == ppr_pkg::OUT_SSP_CLK |=> pin_out[16] == $past(periph_src.sync_clk))
    else $error("sync serial clock not routed to port C pin");

  chk_guard_port_b: assert property (@(posedge clk) disable iff (!arst_n)
    out_sel[9] == ppr_pkg::OUT_GUARD_A |=> pin_out[9] == $past(pin_output_latch[9]))
    else $error("guard output leaked onto port B");

  chk_timer0_route: assert property (@(posedge clk) disable iff (!arst_n)
    out_sel[10] == ppr_pkg::OUT_TIMER0 |=> pin_out[10] == $past(periph_src.timer0_output))
    else $error("timer0 output not routed to port B pin");

  chk_warm_keeps: assert property (@(posedge clk) disable iff (!arst_n)
    warm_rst && !sel_write |=> $stable(out_sel[0]) && !lock)
    else $error("warm reset disturbed selector or kept lock");

  chk_read_upper_zero: assert property (@(posedge clk) disable iff (!arst_n)
    rvalid |-> rdata[31:5] == 27'h000_0000)
    else $error("unused read bits not zero");

  chk_lock_blocks: assert property (@(posedge clk) disable iff (!arst_n)
    lock && do_write && wdec.kind == ppr_pkg::PPR_REG_OUT && wdec.idx == 5'h00 |=> $stable(out_sel[0]))
    else $error("selector changed while locked");

  chk_unlocked_write: assert property (@(posedge clk) disable iff (!arst_n)
    !lock && do_write && w_strb[0] && wdec.kind == ppr_pkg::PPR_REG_IN && wdec.idx == 5'h00
    |=> in_sel[0] == $past(w_data[4:0]))
    else $error("unlocked input selector write lost");

  chk_input_pick: assert property (@(posedge clk) disable iff (!arst_n)
    in_sel[0] == 5'h08 |=> peripheral_input[0] == $past(pin_sync[8]))
    else $error("input selector 0 does not follow port B pin 0");

  chk_read_answer: assert property (@(posedge clk) disable iff (!arst_n)
    arvalid && arready |=> rvalid [*1] ##0 !arready)
    else $error("read answer not one cycle after address");

  chk_ccp_port_a: assert property (@(posedge clk) disable iff (!arst_n)
    out_sel[2] == ppr_pkg::OUT_CAPTURE_COMPARE_UNIT_1 |=> pin_out[2] == $past(pin_output_latch[2]))
    else $error("capture output leaked onto port A");

  chk_pwm_port_c: assert property (@(posedge clk) disable iff (!arst_n)
    out_sel[17] == ppr_pkg::OUT_PULSE_WIDTH_UNIT_3 |=> pin_out[17] == $past(periph_src.pulse_width_unit_3))
    else $error("pulse width output 3 not routed to port C pin");

  chk_mod_route: assert property (@(posedge clk) disable iff (!arst_n)
    out_sel[12] == ppr_pkg::OUT_MOD |=> pin_out[12] == $past(periph_src.signal_modulator_out))
    else $error("modulator output not routed to port B pin");

  chk_unused_code: assert property (@(posedge clk) disable iff (!arst_n)
    out_sel[11] == 5'h0B |=> pin_out[11] == $past(pin_output_latch[11]))
    else $error("unassigned code does not drive the latch");

  chk_in_locked: assert property (@(posedge clk) disable iff (!arst_n)
    lock && do_write && wdec.kind == ppr_pkg::PPR_REG_IN && wdec.idx == 5'h00 |=> $stable(in_sel[0]))
    else $error("input selector changed while locked");

  chk_rsvd_port_low: assert property (@(posedge clk) disable iff (!arst_n)
    in_sel[0][4:3] == ppr_pkg::PORT_RSVD |=> !peripheral_input[0])
    else $error("reserved port selection does not read low");

  chk_lock_write: assert property (@(posedge clk) disable iff (!arst_n)
    do_write && w_strb[0] && wdec.kind == ppr_pkg::PPR_REG_LOCK && !warm_rst
    |=> lock == $past(w_data[ppr_pkg::LOCK_BIT]))
    else $error("lock bit write lost");

endmodule : ppr_pin_router

`default_nettype wire

// ---- tb/ppr_pin_router_tb.sv ----
// Self-checking bench for the pin routing block against a register-level model
`timescale 1ns/1ns
`default_nettype none
module ppr_pin_router_tb;
  localparam int          NP  = ppr_pkg::NUM_PINS;
  localparam int          NI  = ppr_pkg::NUM_INPUTS;
  // Source codes offered on port B or C, on port A or C, and all source codes on any port
  localparam logic [31:0] BC  = 32'h0019_867E;
  localparam logic [31:0] AC  = 32'h00C0_6180;
  localparam logic [31:0] ALL = 32'h00F9_E7FE;
  // Pins and codes that make each pin-level assertion's antecedent true, except chk_latch_on_zero (pin 0, code zero)
  localparam logic [8:0][4:0] DPIN  = {5'h0C, 5'h0B, 5'h11, 5'h02, 5'h0A, 5'h09, 5'h10, 5'h01, 5'h08};
  localparam logic [8:0][4:0] DCODE = {5'h15, 5'h0B, 5'h07, 5'h05, 5'h13, 5'h16, 5'h0F, 5'h09, 5'h01};

  logic                clk;
  logic                arst_n;
  logic                warm_rst;
  logic [11:0]         awaddr;
  logic [11:0]         araddr;
  logic                awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready;
  logic [31:0]         wdata;
  logic [31:0]         rdata;
  logic [3:0]          wstrb;
  logic [1:0]          bresp;
  logic [1:0]          rresp;
  logic [NP-1:0]       pin_output_latch;
  logic [NP-1:0]       pin_in;
  logic [NP-1:0]       pin_out;
  logic [NI-1:0]       peripheral_input;
  logic                routing_locked_flag;
  ppr_pkg::ppr_src_t   periph_src;
  int                  failures;
  int                  check_count;
  int                  cycles = 0;
  int                  seed;
  logic [4:0]          m_out [NP];
  logic [4:0]          m_in [NI];
  logic                m_lock;
  logic [1:0]          resp;
  logic [31:0]         rd;
  logic [31:0]         rnd;

  ppr_pin_router DUT (
    .clk(clk), .arst_n(arst_n), .warm_rst(warm_rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pin_output_latch(pin_output_latch), .periph_src(periph_src), .pin_in(pin_in),
    .pin_out(pin_out), .peripheral_input(peripheral_input), .routing_locked_flag(routing_locked_flag)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, well above the few thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic mreset();
    for (int i = 0; i < NI; i++) m_in[i] = ppr_pkg::IN_DEFAULT[i];
    for (int p = 0; p < NP; p++) m_out[p] = 5'h00;
    m_lock = 1'b0;
  endtask : mreset

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
    // Byte lane 0 off leaves every register alone
    if (!wstrb[0]) return;
    if (a == ppr_pkg::LOCK_ADDR) m_lock = d[0];
    else if (!m_lock && a[1:0] == 2'h0 && a >= ppr_pkg::OUT_BASE && a < ppr_pkg::OUT_BASE + 4 * NP)
      m_out[(a - ppr_pkg::OUT_BASE) >> 2] = d[4:0];
    else if (!m_lock && a[1:0] == 2'h0 && a >= ppr_pkg::IN_BASE && a < ppr_pkg::IN_BASE + 4 * NI)
      m_in[(a - ppr_pkg::IN_BASE) >> 2] = d[4:0];
  endtask : wr

  task automatic rdr(input logic [11:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask : rdr

  task automatic chk_regs();
    for (int i = 0; i < NI; i++) begin
      rdr(12'(ppr_pkg::IN_BASE + 4 * i));
      chk("in_sel", rd, {27'h0, m_in[i]});
    end
    for (int p = 0; p < NP; p++) begin
      rdr(12'(ppr_pkg::OUT_BASE + 4 * p));
      chk("out_sel", rd, {27'h0, m_out[p]});
    end
    rdr(ppr_pkg::LOCK_ADDR);
    chk("lock", rd, {31'h0, m_lock});
  endtask : chk_regs

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic exp_out(logic [4:0] c, int port, logic lt, ppr_pkg::ppr_src_t s);
    int k;
    // Sources sit in the carrier in ascending code order, first code at the top
    k = $countones(ALL & ((32'h1 << c) - 32'h1));
    if (ALL[c] && (port == 2 || c == 5'h15 || (port == 1 ? BC[c] : AC[c]))) return s[18-k];
    return lt;
  endfunction : exp_out

  task automatic stim_chk();
    logic [NP-1:0] ep;
    logic [NI-1:0] ei;
    logic [4:0]    s;
    @(posedge clk);
    pin_in           <= 24'($random(seed));
    pin_output_latch <= 24'($random(seed));
    periph_src       <= 19'($random(seed));
    repeat (4) @(posedge clk);
    for (int p = 0; p < NP; p++) ep[p] = exp_out(m_out[p], p / 8, pin_output_latch[p], periph_src);
    for (int i = 0; i < NI; i++) begin
      s = m_in[i];
      ei[i] = (s[4:3] != 2'h3 && ppr_pkg::IN_PORTS[i][s[4:3]]) ? pin_in[s] : 1'b0;
    end
    chk("pin_out", 32'(pin_out), 32'(ep));
    chk("periph_in", 32'(peripheral_input), 32'(ei));
  endtask : stim_chk

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h09b7;
    failures = 0;
    check_count = 0;
    arst_n = 1'b0;
    warm_rst = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    pin_in = '0;
    pin_output_latch = '0;
    periph_src = '0;
    mreset();
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_regs();
    wr(12'h300, 32'h0000_001F);
    chk("bresp_unmapped", 32'(resp), 32'(ppr_pkg::RESP_SLVERR));
    rdr(12'h202);
    chk("rresp_unaligned", 32'(resp), 32'(ppr_pkg::RESP_SLVERR));
    chk("rdata_unaligned", rd, 32'h0000_0000);
    // Every code, on one pin of each port
    for (int c = 0; c < 32; c++) begin
      for (int pt = 0; pt < 3; pt++) begin
        rnd = $random(seed);
        wr(12'(ppr_pkg::OUT_BASE + 32 * pt + 4 * rnd[2:0]), {rnd[31:5], 5'(c)});
      end
      repeat (2) stim_chk();
    end
    // Random input selections, reserved and unlisted ports included
    repeat (60) begin
      rnd = $random(seed);
      wr(12'(ppr_pkg::IN_BASE + 4 * (rnd[15:0] % NI)), $random(seed));
      stim_chk();
    end
    wstrb <= 4'hE;
    wr(12'(ppr_pkg::OUT_BASE + 4), $random(seed));
    wstrb <= 4'hF;
    chk_regs();
    wr(ppr_pkg::LOCK_ADDR, 32'hFFFF_FFFF);
    repeat (2) @(posedge clk);
    chk("locked_flag", 32'(routing_locked_flag), 32'h1);
    wr(ppr_pkg::OUT_BASE, 32'h0000_0001);
    wr(ppr_pkg::IN_BASE, 32'h0000_0000);
    chk("bresp_locked", 32'(resp), 32'(ppr_pkg::RESP_OKAY));
    stim_chk();
    chk_regs();
    wr(ppr_pkg::LOCK_ADDR, 32'h0000_0000);
    wr(12'(ppr_pkg::OUT_BASE + 32), 32'h0000_0013);
    for (int j = 0; j < 9; j++) wr(12'(ppr_pkg::OUT_BASE + 4 * DPIN[j]), {27'h0, DCODE[j]});
    wr(ppr_pkg::IN_BASE, 32'h0000_0018);
    stim_chk();
    chk_regs();
    // Warm reset drops the lock but keeps every selection
    wr(ppr_pkg::LOCK_ADDR, 32'h0000_0001);
    @(posedge clk);
    warm_rst <= 1'b1;
    @(posedge clk);
    warm_rst <= 1'b0;
    m_lock = 1'b0;
    repeat (2) @(posedge clk);
    chk("flag_warm", 32'(routing_locked_flag), 32'h0);
    chk_regs();
    stim_chk();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    mreset();
    repeat (3) @(posedge clk);
    chk_regs();
    stim_chk();
    print_verdict();
  end
endmodule : ppr_pin_router_tb
`default_nettype wire
